// ### rtl/fault_stop_ctrl.sv
// fault-stop controller: stop-mode registers, class decode and stop sequence
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module fault_stop_ctrl (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // fault report and drive inputs
   input wire logic fault_valid_i,
   input wire logic [9:0] fault_code_i,
   input wire logic overtravel_i,
   input wire logic drive_enable_i,
   input wire logic [15:0] motor_speed_i,
   // power stage controls
   output logic power_enable_o,
   output logic brake_current_en_o,
   output logic stop_active_o,
   output logic [2:0] stop_state_o,
   output logic [15:0] speed_ref_o,
   // interrupt
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] cl2_mode_q;
   logic [15:0] cl3_mode_q;
   logic [15:0] ot_mode_q;
   logic [15:0] fast_ms_q;
   logic [15:0] slow_ms_q;
   logic [15:0] rated_q;
   logic [4:0] irq_stat_q;
   logic [4:0] irq_stat_d;
   logic [4:0] irq_mask_q;
   logic [15:0] rdata_q;
   logic ot_s1_q;
   logic ot_s2_q;
   logic ot_s3_q;
   logic en_s1_q;
   logic en_s2_q;
   logic power_q;
   logic brake_q;
   logic active_q;
   logic irq_q;
   fault_stop_pkg::stop_state_t state_q;
   fault_stop_pkg::stop_state_t state_d;

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   logic wr_cl2;
   logic wr_cl3;
   logic wr_ot;
   logic wr_fast;
   logic wr_slow;
   logic wr_rated;
   logic wr_stat;
   logic wr_mask;
   logic mode_ok;
   logic [15:0] rd_mux;
   assign wr_cl2 = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_CL2_MODE;
   assign wr_cl3 = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_CL3_MODE;
   assign wr_ot = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_OT_MODE;
   assign wr_fast = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_FAST_MS;
   assign wr_slow = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_SLOW_MS;
   assign wr_rated = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_RATED;
   assign wr_stat = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_IRQ_STAT;
   assign wr_mask = reg_wr_i && reg_addr_i == fault_stop_pkg::ADDR_IRQ_MASK;
   // a mode outside 0..5 is refused and the old value kept
   assign mode_ok = reg_wdata_i <= fault_stop_pkg::MODE_BRAKE;

   // read selection, unmapped words read zero
   always_comb begin
      unique case (reg_addr_i)
         fault_stop_pkg::ADDR_CL2_MODE: rd_mux = cl2_mode_q;
         fault_stop_pkg::ADDR_CL3_MODE: rd_mux = cl3_mode_q;
         fault_stop_pkg::ADDR_OT_MODE: rd_mux = ot_mode_q;
         fault_stop_pkg::ADDR_FAST_MS: rd_mux = fast_ms_q;
         fault_stop_pkg::ADDR_SLOW_MS: rd_mux = slow_ms_q;
         fault_stop_pkg::ADDR_RATED: rd_mux = rated_q;
         fault_stop_pkg::ADDR_IRQ_STAT: rd_mux = {11'h000, irq_stat_q};
         fault_stop_pkg::ADDR_IRQ_MASK: rd_mux = {11'h000, irq_mask_q};
         fault_stop_pkg::ADDR_STATE: rd_mux = {13'h0, state_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   // settings store; each takes effect on the next cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cl2_mode_q <= fault_stop_pkg::RST_MODE;
         cl3_mode_q <= fault_stop_pkg::RST_MODE;
         ot_mode_q <= fault_stop_pkg::RST_MODE;
         fast_ms_q <= fault_stop_pkg::RST_FAST_MS;
         slow_ms_q <= fault_stop_pkg::RST_SLOW_MS;
         rated_q <= fault_stop_pkg::RST_RATED;
         irq_mask_q <= fault_stop_pkg::RST_IRQ;
      end else begin
         if (wr_cl2 && mode_ok) cl2_mode_q <= reg_wdata_i;
         if (wr_cl3 && mode_ok) cl3_mode_q <= reg_wdata_i;
         if (wr_ot && mode_ok) ot_mode_q <= reg_wdata_i;
         if (wr_fast) fast_ms_q <= reg_wdata_i;
         if (wr_slow) slow_ms_q <= reg_wdata_i;
         if (wr_rated) rated_q <= reg_wdata_i;
         if (wr_mask) irq_mask_q <= reg_wdata_i[4:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) rdata_q <= 16'h0000;
      else rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ot_s1_q <= 1'b0;
         ot_s2_q <= 1'b0;
         ot_s3_q <= 1'b0;
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
      end else begin
         ot_s1_q <= overtravel_i;
         ot_s2_q <= ot_s1_q;
         ot_s3_q <= ot_s2_q;
         en_s1_q <= drive_enable_i;
         en_s2_q <= en_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault classification and event bits
   logic is_cl1;
   logic is_cl2;
   logic is_cl3;
   logic ot_hit;
   logic done_ev;
   logic [4:0] set_vec;
   assign is_cl1 = fault_valid_i && fault_code_i >= fault_stop_pkg::CL1_LO
      && fault_code_i <= fault_stop_pkg::CL1_HI;
   assign is_cl2 = fault_valid_i && fault_code_i >= fault_stop_pkg::CL2_LO
      && fault_code_i <= fault_stop_pkg::CL2_HI;
   assign is_cl3 = fault_valid_i && fault_code_i >= fault_stop_pkg::CL3_LO
      && fault_code_i <= fault_stop_pkg::CL3_HI;
   // a limit counts only when reached with the motor turning
   assign ot_hit = ot_s2_q && !ot_s3_q && state_q == fault_stop_pkg::ST_RUN
      && motor_speed_i != 16'h0000;
   assign set_vec = {done_ev, ot_hit, is_cl3, is_cl2, is_cl1};
   // write one clears, a new event in the same cycle wins
   assign irq_stat_d = (irq_stat_q & ~(wr_stat ? reg_wdata_i[4:0] : 5'h00)) | set_vec;

   // sticky status
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) irq_stat_q <= fault_stop_pkg::RST_IRQ;
      else irq_stat_q <= irq_stat_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // stop cause selection, most severe first
   logic c1;
   logic c2;
   logic c3;
   logic ot;
   logic stop_any;
   logic [15:0] sel_mode;
   logic coast_sel;
   logic brake_sel;
   logic keep_sel;
   logic fast_sel;
   logic [15:0] sel_ms;
   logic ramp_zero;
   logic ramp_load;
   logic [15:0] ramp_speed;
   logic motor_zero;
   assign c1 = irq_stat_q[fault_stop_pkg::B_CL1];
   assign c2 = irq_stat_q[fault_stop_pkg::B_CL2];
   assign c3 = irq_stat_q[fault_stop_pkg::B_CL3];
   assign ot = ot_s2_q;
   assign stop_any = c1 || c2 || c3 || ot;
   // class II outranks over-travel, which outranks class III
   assign sel_mode = c2 ? cl2_mode_q : (ot ? ot_mode_q : cl3_mode_q);
   assign coast_sel = c1 || sel_mode == fault_stop_pkg::MODE_COAST;
   assign brake_sel = sel_mode == fault_stop_pkg::MODE_BRAKE;
   assign keep_sel = sel_mode == fault_stop_pkg::MODE_FAST_KEEP
      || sel_mode == fault_stop_pkg::MODE_SLOW_KEEP;
   assign fast_sel = sel_mode == fault_stop_pkg::MODE_FAST_OFF
      || sel_mode == fault_stop_pkg::MODE_FAST_KEEP;
   // live time setting feeds the ramp, so a rewrite bends it mid-stop
   assign sel_ms = fast_sel ? fast_ms_q : slow_ms_q;
   assign motor_zero = motor_speed_i == 16'h0000;
   // the ramp starts from the speed at the moment the stop begins, and tracks
   // the shaft while braking so a switch back to a ramp starts from the real speed
   assign ramp_load = stop_any && (state_q == fault_stop_pkg::ST_RUN
      || state_q == fault_stop_pkg::ST_BRAKE);

   decel_ramp u_ramp (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(ramp_load),
      .en_i(state_q == fault_stop_pkg::ST_RAMP),
      .start_speed_i(motor_speed_i),
      .rated_speed_i(rated_q),
      .decel_ms_i(sel_ms),
      .speed_o(ramp_speed),
      .zero_o(ramp_zero)
   );

   ////////////////////////////////////////////////////////////////////////////
   // stop sequence; mode changes are followed from ramp and brake, a hold leaving the keep modes goes to off
   always_comb begin
      state_d = state_q;
      if (!stop_any) begin
         state_d = fault_stop_pkg::ST_RUN;
      end else begin
         unique case (state_q)
            fault_stop_pkg::ST_RUN: begin
               if (coast_sel) state_d = fault_stop_pkg::ST_COAST;
               else if (brake_sel) state_d = fault_stop_pkg::ST_BRAKE;
               else state_d = fault_stop_pkg::ST_RAMP;
            end
            fault_stop_pkg::ST_RAMP: begin
               if (coast_sel) state_d = fault_stop_pkg::ST_COAST;
               else if (brake_sel) state_d = fault_stop_pkg::ST_BRAKE;
               else if (ramp_zero && keep_sel) state_d = fault_stop_pkg::ST_HOLD;
               else if (ramp_zero) state_d = fault_stop_pkg::ST_OFF;
            end
            fault_stop_pkg::ST_BRAKE: begin
               if (coast_sel) state_d = fault_stop_pkg::ST_COAST;
               else if (!brake_sel) state_d = fault_stop_pkg::ST_RAMP;
               else if (motor_zero) state_d = fault_stop_pkg::ST_OFF;
            end
            fault_stop_pkg::ST_HOLD: begin
               // the outside controller ends the hold by dropping enable
               if (coast_sel || !keep_sel || !en_s2_q) state_d = fault_stop_pkg::ST_OFF;
            end
            fault_stop_pkg::ST_COAST: begin
               if (motor_zero) state_d = fault_stop_pkg::ST_OFF;
            end
            fault_stop_pkg::ST_OFF: state_d = fault_stop_pkg::ST_OFF;
            default: state_d = fault_stop_pkg::ST_OFF;
         endcase
      end
   end

   // stop reached: entry into off or hold, except off reached from coast
   assign done_ev = (state_d == fault_stop_pkg::ST_OFF || state_d == fault_stop_pkg::ST_HOLD)
      && state_q != state_d && state_q != fault_stop_pkg::ST_COAST;

   // state and registered outputs
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= fault_stop_pkg::ST_RUN;
         power_q <= 1'b0;
         brake_q <= 1'b0;
         active_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         power_q <= state_d == fault_stop_pkg::ST_RUN ? en_s2_q :
            (state_d == fault_stop_pkg::ST_RAMP || state_d == fault_stop_pkg::ST_BRAKE
             || state_d == fault_stop_pkg::ST_HOLD);
         brake_q <= state_d == fault_stop_pkg::ST_BRAKE;
         active_q <= state_d != fault_stop_pkg::ST_RUN;
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign reg_rdata_o = rdata_q;
   assign power_enable_o = power_q;
   assign brake_current_en_o = brake_q;
   assign stop_active_o = active_q;
   assign stop_state_o = state_q;
   assign speed_ref_o = ramp_speed;
   assign irq_o = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_class1_cuts_power: assert property (
      is_cl1 |-> ##2 !power_enable_o && !brake_current_en_o)
      else $error("class I fault did not cut power");
   a_mode_write_refused: assert property (
      wr_cl2 && reg_wdata_i > fault_stop_pkg::MODE_BRAKE |=> $stable(cl2_mode_q))
      else $error("out of range mode accepted");
   a_class2_decode: assert property (
      fault_valid_i && fault_code_i == 10'h0C8 |=> irq_stat_q[fault_stop_pkg::B_CL2])
      else $error("code 200 not taken as class II");
   a_class3_decode: assert property (
      fault_valid_i && fault_code_i == 10'h257 |=> !irq_stat_q[fault_stop_pkg::B_CL3])
      else $error("code 599 taken as class III");
   a_set_beats_clear: assert property (
      is_cl2 && wr_stat && reg_wdata_i[1] |=> irq_stat_q[fault_stop_pkg::B_CL2])
      else $error("event lost against clear");
   a_hold_powered: assert property (
      state_q == fault_stop_pkg::ST_HOLD |-> power_enable_o && !brake_current_en_o)
      else $error("hold without power");
   a_hold_ends: assert property (
      state_q == fault_stop_pkg::ST_HOLD && !en_s2_q |=> state_q == fault_stop_pkg::ST_OFF ##1 !power_enable_o)
      else $error("hold kept after enable dropped");
   a_ramp_falls: assert property (
      state_q == fault_stop_pkg::ST_RAMP && $past(state_q) == fault_stop_pkg::ST_RAMP
      |-> speed_ref_o <= $past(speed_ref_o))
      else $error("ramp speed rose");
   a_zero_time_stop: assert property (
      state_q == fault_stop_pkg::ST_RAMP && sel_ms == 16'h0000 |=> speed_ref_o == 16'h0000)
      else $error("zero time ramp not immediate");
   // read data stands one cycle, then falls back to zero unless read again
   a_read_data: assert property (
      reg_rd_i && reg_addr_i == fault_stop_pkg::ADDR_FAST_MS |=> reg_rdata_o == $past(fast_ms_q)
      ##1 reg_rdata_o == 16'h0000 || $past(reg_rd_i))
      else $error("read data wrong");
   a_irq_masked: assert property (
      irq_mask_q == 5'h00 |=> !irq_o)
      else $error("masked interrupt raised");

   c_class1_coast: cover property (is_cl1 ##[1:4] state_q == fault_stop_pkg::ST_COAST);
   c_ramp_to_hold: cover property (state_q == fault_stop_pkg::ST_RAMP ##1 state_q == fault_stop_pkg::ST_HOLD);
   c_brake_off: cover property (state_q == fault_stop_pkg::ST_BRAKE ##1 state_q == fault_stop_pkg::ST_OFF);
   c_ramp_to_off: cover property (state_q == fault_stop_pkg::ST_RAMP ##1 state_q == fault_stop_pkg::ST_OFF);
endmodule

// ### rtl/fault_stop_pkg.sv
// constants, register map and state encoding of the fault-stop controller
package fault_stop_pkg;
   // clock rate and derived cycles per millisecond
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
   ////////////////////////////////////////////////////////////////////////////
   // register word addresses
   localparam logic [3:0] ADDR_CL2_MODE = 4'h0;
   localparam logic [3:0] ADDR_CL3_MODE = 4'h1;
   localparam logic [3:0] ADDR_OT_MODE = 4'h2;
   localparam logic [3:0] ADDR_FAST_MS = 4'h3;
   localparam logic [3:0] ADDR_SLOW_MS = 4'h4;
   localparam logic [3:0] ADDR_RATED = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
   localparam logic [3:0] ADDR_STATE = 4'h8;
   // values after reset
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_FAST_MS = 16'h01F4;
   localparam logic [15:0] RST_SLOW_MS = 16'h03E8;
   localparam logic [15:0] RST_RATED = 16'h0BB8;
   localparam logic [4:0] RST_IRQ = 5'h00;
   ////////////////////////////////////////////////////////////////////////////
   // stop-mode encoding
   localparam logic [15:0] MODE_COAST = 16'h0000;
   localparam logic [15:0] MODE_FAST_OFF = 16'h0001;
   localparam logic [15:0] MODE_SLOW_OFF = 16'h0002;
   localparam logic [15:0] MODE_FAST_KEEP = 16'h0003;
   localparam logic [15:0] MODE_SLOW_KEEP = 16'h0004;
   localparam logic [15:0] MODE_BRAKE = 16'h0005;
   // fault code class bounds
   localparam logic [9:0] CL1_LO = 10'h064;
   localparam logic [9:0] CL1_HI = 10'h0C7;
   localparam logic [9:0] CL2_LO = 10'h0C8;
   localparam logic [9:0] CL2_HI = 10'h257;
   localparam logic [9:0] CL3_LO = 10'h258;
   localparam logic [9:0] CL3_HI = 10'h3E7;
   // status bit positions
   localparam int unsigned IRQ_W = 5;
   localparam int unsigned B_CL1 = 0;
   localparam int unsigned B_CL2 = 1;
   localparam int unsigned B_CL3 = 2;
   localparam int unsigned B_OT = 3;
   localparam int unsigned B_DONE = 4;
   ////////////////////////////////////////////////////////////////////////////
   // stop sequence states
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_COAST = 3'b001,
      ST_RAMP = 3'b010,
      ST_BRAKE = 3'b011,
      ST_HOLD = 3'b100,
      ST_OFF = 3'b101
   } stop_state_t;
endpackage

// ### rtl/decel_ramp.sv
// linear speed ramp from a start speed down to zero
module decel_ramp (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // control
   input wire logic load_i,
   input wire logic en_i,
   input wire logic [15:0] start_speed_i,
   input wire logic [15:0] rated_speed_i,
   input wire logic [15:0] decel_ms_i,
   // ramp state
   output logic [15:0] speed_o,
   output logic zero_o
);
   logic [15:0] speed_q;
   logic [31:0] acc_q;
   logic [31:0] total;
   logic [31:0] sum;
   logic step;

   // rated speed is shed over total cycles, so a lower start speed ends sooner
   assign total = 32'(decel_ms_i) * 32'(fault_stop_pkg::CYC_PER_MS);
   assign sum = acc_q + 32'(rated_speed_i);
   assign step = sum >= total;
   assign speed_o = speed_q;
   assign zero_o = speed_q == 16'h0000;

   // one count at most per cycle; acc stays below total while rated is at most total, and sum cannot wrap
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || load_i) begin
         speed_q <= sys_rst_i ? 16'h0000 : start_speed_i;
         acc_q <= 32'h0000_0000;
      end else if (en_i) begin
         if (total == 32'h0000_0000 || zero_o) begin
            speed_q <= 16'h0000; // zero time stops at once
         end else if (step) begin
            speed_q <= speed_q - 16'h0001;
            acc_q <= sum - total;
         end else begin
            acc_q <= sum;
         end
      end
   end
endmodule

// ### tb/motor_model.sv
// behavioural motor and power stage that feeds speed back to the fault-stop block
module motor_model (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // controls from the block
   input wire logic power_enable_i,
   input wire logic stop_active_i,
   input wire logic [2:0] stop_state_i,
   input wire logic [15:0] speed_ref_i,
   // commanded running speed and measured speed
   input wire logic [15:0] set_speed_i,
   output logic [15:0] motor_speed_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ramp follows the reference; unpowered or braking shafts lose speed by friction
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         motor_speed_o <= 16'h0000;
      end else if (stop_state_i == fault_stop_pkg::ST_RAMP) begin
         motor_speed_o <= speed_ref_i;
      end else if (!power_enable_i || stop_active_i) begin
         motor_speed_o <= (motor_speed_o > 16'h0008) ? motor_speed_o - 16'h0008 : 16'h0000;
      end else begin
         motor_speed_o <= set_speed_i;
      end
   end
endmodule

// ### tb/testbench.sv
// self-checking bench for the fault-stop controller
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, fault_valid_i = 1'b0;
   logic overtravel_i = 1'b0, drive_enable_i = 1'b1, power_enable_o, brake_current_en_o, stop_active_o, irq_o;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, motor_speed_i, speed_ref_o, set_speed = 16'h012C;
   logic [9:0] fault_code_i = 10'h000;
   logic [2:0] stop_state_o;
   int error_cnt = 0, check_count = 0, n;
   ////////////////////////////////////////////////////////////////////////////
   // design, motor and clock
   fault_stop_ctrl DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .fault_valid_i(fault_valid_i), .fault_code_i(fault_code_i), .overtravel_i(overtravel_i),
      .drive_enable_i(drive_enable_i), .motor_speed_i(motor_speed_i), .power_enable_o(power_enable_o),
      .brake_current_en_o(brake_current_en_o), .stop_active_o(stop_active_o), .stop_state_o(stop_state_o),
      .speed_ref_o(speed_ref_o), .irq_o(irq_o));
   motor_model motor (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .power_enable_i(power_enable_o),
      .stop_active_i(stop_active_o), .stop_state_i(stop_state_o), .speed_ref_i(speed_ref_o),
      .set_speed_i(set_speed), .motor_speed_o(motor_speed_i));
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   // verdict, comparison and bus tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask
   task automatic fault(input logic [9:0] code);
      @(posedge sys_clk_i);
      fault_valid_i <= 1'b1;
      fault_code_i <= code;
      @(posedge sys_clk_i);
      fault_valid_i <= 1'b0;
   endtask
   // bounded wait for a stop state, returns the cycles spent
   task automatic wait_st(input logic [2:0] s, output int cnt);
      cnt = 0;
      while (stop_state_o !== s) begin
         @(posedge sys_clk_i);
         #1 cnt++;
         if (cnt > 9000) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, stop_state_o, s);
            close_out();
         end
      end
   endtask
   task automatic recover();
      overtravel_i <= 1'b0;
      drive_enable_i <= 1'b1;
      wr(fault_stop_pkg::ADDR_IRQ_STAT, 16'h001F);
      wait_st(fault_stop_pkg::ST_RUN, n);
      repeat (20) @(posedge sys_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs();
      rd_chk(fault_stop_pkg::ADDR_CL2_MODE, 16'h0000);
      rd_chk(fault_stop_pkg::ADDR_CL3_MODE, 16'h0000);
      rd_chk(fault_stop_pkg::ADDR_OT_MODE, 16'h0000);
      rd_chk(fault_stop_pkg::ADDR_FAST_MS, 16'h01F4);
      rd_chk(fault_stop_pkg::ADDR_SLOW_MS, 16'h03E8);
      rd_chk(fault_stop_pkg::ADDR_RATED, fault_stop_pkg::RST_RATED);
      rd_chk(4'hB, 16'h0000);
      wr(fault_stop_pkg::ADDR_CL2_MODE, 16'h0005);
      wr(fault_stop_pkg::ADDR_CL2_MODE, 16'h0006);
      rd_chk(fault_stop_pkg::ADDR_CL2_MODE, 16'h0005);
      wr(fault_stop_pkg::ADDR_FAST_MS, 16'hFFFF);
      rd_chk(fault_stop_pkg::ADDR_FAST_MS, 16'hFFFF);
      $display("test regs done");
   endtask
   task automatic t_class1();
      wr(fault_stop_pkg::ADDR_IRQ_MASK, 16'h0001);
      rd_chk(fault_stop_pkg::ADDR_IRQ_MASK, 16'h0001);
      fault(10'h096);
      repeat (2) @(posedge sys_clk_i);
      #1 chk({15'h0, power_enable_o}, 16'h0000);
      chk({13'h0, stop_state_o}, {13'h0, fault_stop_pkg::ST_COAST});
      chk({15'h0, stop_active_o}, 16'h0001);
      chk({15'h0, irq_o}, 16'h0001);
      fault(10'h3E8);
      recover();
      #1 chk({15'h0, irq_o}, 16'h0000);
      chk({15'h0, stop_active_o}, 16'h0000);
      chk({15'h0, power_enable_o}, 16'h0001);
      $display("test class1 done");
   endtask
   task automatic t_fast_ramp();
      wr(fault_stop_pkg::ADDR_CL2_MODE, fault_stop_pkg::MODE_FAST_OFF);
      wr(fault_stop_pkg::ADDR_FAST_MS, 16'h0001);
      fault(10'h0C8);
      wait_st(fault_stop_pkg::ST_RAMP, n);
      chk(speed_ref_o, set_speed);
      wait_st(fault_stop_pkg::ST_OFF, n);
      chk(16'(n >= 1990 && n <= 2010), 16'h0001);
      chk(speed_ref_o, 16'h0000);
      chk({15'h0, power_enable_o}, 16'h0000);
      recover();
      $display("test fast ramp done");
   endtask
   task automatic t_slow_keep();
      wr(fault_stop_pkg::ADDR_OT_MODE, fault_stop_pkg::MODE_SLOW_KEEP);
      wr(fault_stop_pkg::ADDR_SLOW_MS, 16'h0002);
      overtravel_i <= 1'b1;
      wait_st(fault_stop_pkg::ST_RAMP, n);
      wait_st(fault_stop_pkg::ST_HOLD, n);
      chk(16'(n >= 3990 && n <= 4010), 16'h0001);
      chk({15'h0, power_enable_o}, 16'h0001);
      @(posedge sys_clk_i);
      drive_enable_i <= 1'b0;
      wait_st(fault_stop_pkg::ST_OFF, n);
      chk({15'h0, power_enable_o}, 16'h0000);
      recover();
      $display("test slow keep done");
   endtask
   task automatic t_severity();
      wr(fault_stop_pkg::ADDR_CL3_MODE, fault_stop_pkg::MODE_COAST);
      fault(10'h257);
      fault(10'h258);
      wait_st(fault_stop_pkg::ST_RAMP, n);
      repeat (50) @(posedge sys_clk_i);
      #1 chk({13'h0, stop_state_o}, {13'h0, fault_stop_pkg::ST_RAMP});
      chk({15'h0, power_enable_o}, 16'h0001);
      wr(fault_stop_pkg::ADDR_CL2_MODE, fault_stop_pkg::MODE_BRAKE);
      repeat (3) @(posedge sys_clk_i);
      #1 chk({15'h0, brake_current_en_o}, 16'h0001);
      // back to a fast ramp of zero time while braking: speed drops at once
      wr(fault_stop_pkg::ADDR_FAST_MS, 16'h0000);
      wr(fault_stop_pkg::ADDR_CL2_MODE, fault_stop_pkg::MODE_FAST_OFF);
      wait_st(fault_stop_pkg::ST_OFF, n);
      chk(16'(n <= 4), 16'h0001);
      chk(speed_ref_o, 16'h0000);
      chk({15'h0, power_enable_o}, 16'h0000);
      recover();
      $display("test severity done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      t_regs();
      t_class1();
      t_fast_ramp();
      t_slow_keep();
      t_severity();
      close_out();
   end
endmodule
